// ==== src/wpp_pkg.sv ====
// Types shared by the wiper pot serial frame port
package wpp_pkg;
  // Controller states, one-hot
  typedef enum logic [2:0] {
    WPP_ST_IDLE  = 3'b001,
    WPP_ST_FRAME = 3'b010,
    WPP_ST_BUSY  = 3'b100
  } wpp_state_e;
  typedef logic [15:0] wpp_word_t;
  typedef logic [9:0] wpp_data_t;
  typedef logic [3:0] wpp_cmd_t;
  typedef logic [19:0] wpp_cnt_t;
endpackage

// ==== src/wpp_port.sv ====
// Serial frame port of a single-channel digital potentiometer
// How it works
// - 16-bit shift register, capture on falling clock
// - Serial clock well below 50 MHz at 125 MHz sampling
// - Frame-select fall opens frame, enables shifting
// - Frame-select rise after a whole multiple of 16 clocks commits
// - Early rise aborts, no register changes
// - Open-drain output shifts out register contents
// - Ready output marks finished register/memory operations
// - MSB first: two zeros, command, data
// - Bits counted in whole frames of 16
// - Nonvolatile store locks the shift register
// - Read data appears in following frame
`include "wpp_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module wpp_port
  import wpp_pkg::*;
#(
  // Store time in cycles; shorten for simulation
  parameter wpp_cnt_t STORE_CYCLES = 20'(`WPP_STORE_MS * `WPP_SYS_CLK_KHZ)
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic sclk_in,
  input wire logic sync_n_in,
  input wire logic din_in,
  input wire logic serial_out_od_in,
  output logic serial_out_od_out,
  output logic serial_out_od_oe_out,
  input wire logic ready_od_in,
  output logic ready_od_out,
  output logic ready_od_oe_out,
  output logic [9:0] wiper_setting_out,
  output logic [3:0] ctrl_out,
  output logic shutdown_out
);
  // --------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------
  // Sampling at 125 MHz resolves a link clock well below the
  // 50 MHz limit only; full rate needs a faster sampling clock.
  logic sclk_f, sync_n_f, din_f; // Filtered pin levels
  wpp_sync3 u_sync_sclk (.clk_in(sys_clk_in), .rst_in(rst_in), .d_in(sclk_in), .q_out(sclk_f));
  wpp_sync3 u_sync_sync (.clk_in(sys_clk_in), .rst_in(rst_in), .d_in(sync_n_in), .q_out(sync_n_f));
  wpp_sync3 u_sync_din (.clk_in(sys_clk_in), .rst_in(rst_in), .d_in(din_in), .q_out(din_f));

  // --------------------------------------------------
  // State
  // --------------------------------------------------
  wpp_state_e state_reg, state_next; // Controller state
  logic sclk_q_reg, sync_q_reg; // Previous levels for edges
  wpp_word_t shift_reg, shift_next; // Serial shift register
  logic [3:0] bit_cnt_reg, bit_cnt_next; // Bits within current 16
  logic got_word_reg, got_word_next; // At least one whole word seen
  wpp_data_t wiper_setting_reg, wiper_next; // Wiper position
  wpp_data_t otp_wiper_memory, otp_next; // Stored wiper value
  logic [3:0] ctrl_reg, ctrl_next; // Control bits
  logic shdn_reg, shdn_next; // Shutdown flag
  logic rd_pend_reg, rd_pend_next; // Readback waits for next frame
  wpp_word_t rd_word_reg, rd_word_next; // Word to present
  wpp_cnt_t busy_cnt_reg, busy_cnt_next; // Cycles left in operation
  logic store_reg, store_next; // Store in progress, locks shifting
  logic sdo_oe_reg, sdo_oe_next; // Open-drain pull-low enable
  logic rdy_oe_reg, rdy_oe_next; // Ready pull-low enable

  logic sclk_fall, sync_fall, sync_rise;
  wpp_cmd_t cmd;
  wpp_data_t data;
  assign sclk_fall = sclk_q_reg & ~sclk_f;
  assign sync_fall = sync_q_reg & ~sync_n_f;
  assign sync_rise = ~sync_q_reg & sync_n_f;
  assign cmd = shift_reg[`WPP_CMD_HI:`WPP_CMD_LO];
  assign data = shift_reg[`WPP_DATA_HI:`WPP_DATA_LO];

  // --------------------------------------------------
  // Next-state logic
  // --------------------------------------------------
  always_comb begin
    state_next = state_reg;
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    got_word_next = got_word_reg;
    wiper_next = wiper_setting_reg;
    otp_next = otp_wiper_memory;
    ctrl_next = ctrl_reg;
    shdn_next = shdn_reg;
    rd_pend_next = rd_pend_reg;
    rd_word_next = rd_word_reg;
    busy_cnt_next = busy_cnt_reg;
    store_next = store_reg;
    unique case (state_reg)
      WPP_ST_IDLE: begin
        // Open a frame; a pending read loads its word first
        if (sync_fall) begin
          state_next = WPP_ST_FRAME;
          bit_cnt_next = `WPP_BIT_ZERO;
          got_word_next = 1'b0;
          if (rd_pend_reg) begin
            shift_next = rd_word_reg;
            rd_pend_next = 1'b0;
          end
        end
      end
      WPP_ST_FRAME: begin
        if (sync_rise) begin
          state_next = WPP_ST_IDLE;
          // Commit only on a whole number of words
          if (got_word_reg && bit_cnt_reg == `WPP_BIT_ZERO) begin
            state_next = WPP_ST_BUSY;
            busy_cnt_next = `WPP_OP_CYCLES;
            unique case (cmd)
              `WPP_CMD_WR_WIPER: wiper_next = data;
              `WPP_CMD_RD_WIPER: begin
                rd_pend_next = 1'b1;
                rd_word_next = {6'h00, wiper_setting_reg};
              end
              `WPP_CMD_STORE: begin
                // Store only when programming is enabled
                if (ctrl_reg[`WPP_CTRL_PROG_EN]) begin
                  otp_next = wiper_setting_reg;
                  busy_cnt_next = STORE_CYCLES;
                  store_next = 1'b1;
                end
              end
              `WPP_CMD_REFRESH: wiper_next = otp_wiper_memory;
              `WPP_CMD_RD_OTP: begin
                rd_pend_next = 1'b1;
                rd_word_next = {6'h00, otp_wiper_memory};
              end
              `WPP_CMD_WR_CTRL: ctrl_next = data[3:0];
              `WPP_CMD_RD_CTRL: begin
                rd_pend_next = 1'b1;
                rd_word_next = {12'h000, ctrl_reg};
              end
              `WPP_CMD_SHDN: shdn_next = data[0];
              default: busy_cnt_next = `WPP_OP_CYCLES; // Nop and unused codes
            endcase
          end
          // Otherwise the partial frame is simply dropped
        end else if (sclk_fall) begin
          shift_next = {shift_reg[14:0], din_f};
          bit_cnt_next = bit_cnt_reg + 4'h1;
          if (bit_cnt_reg == `WPP_BIT_LAST) begin
            got_word_next = 1'b1;
          end
        end
      end
      WPP_ST_BUSY: begin
        // Frames are ignored while the operation runs
        if (busy_cnt_reg <= `WPP_OP_CYCLES) begin
          state_next = WPP_ST_IDLE;
          store_next = 1'b0;
          busy_cnt_next = 20'h0_0000;
        end else begin
          busy_cnt_next = busy_cnt_reg - `WPP_OP_CYCLES;
        end
      end
      default: state_next = WPP_ST_IDLE;
    endcase
    // Pull low while the shifted-out bit is zero, in a frame only
    sdo_oe_next = (state_next == WPP_ST_FRAME) & ~shift_next[`WPP_MSB];
    // Ready pulled low while an operation is in progress
    rdy_oe_next = (state_next == WPP_ST_BUSY);
  end

  // --------------------------------------------------
  // Registers
  // --------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_reg <= WPP_ST_IDLE;
      sclk_q_reg <= 1'b1;
      sync_q_reg <= 1'b1;
      shift_reg <= `WPP_WORD_ZERO;
      bit_cnt_reg <= `WPP_BIT_ZERO;
      got_word_reg <= 1'b0;
      wiper_setting_reg <= `WPP_WIPER_RST;
      otp_wiper_memory <= `WPP_WIPER_RST;
      ctrl_reg <= `WPP_CTRL_RST;
      shdn_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      rd_word_reg <= `WPP_WORD_ZERO;
      busy_cnt_reg <= 20'h0_0000;
      store_reg <= 1'b0;
      sdo_oe_reg <= 1'b0;
      rdy_oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sclk_q_reg <= sclk_f;
      sync_q_reg <= sync_n_f;
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      got_word_reg <= got_word_next;
      wiper_setting_reg <= wiper_next;
      otp_wiper_memory <= otp_next;
      ctrl_reg <= ctrl_next;
      shdn_reg <= shdn_next;
      rd_pend_reg <= rd_pend_next;
      rd_word_reg <= rd_word_next;
      busy_cnt_reg <= busy_cnt_next;
      store_reg <= store_next;
      sdo_oe_reg <= sdo_oe_next;
      rdy_oe_reg <= rdy_oe_next;
    end
  end

  // Open-drain pins only ever drive low
  assign serial_out_od_out = 1'b0;
  assign serial_out_od_oe_out = sdo_oe_reg;
  assign ready_od_out = 1'b0;
  assign ready_od_oe_out = rdy_oe_reg;
  assign wiper_setting_out = wiper_setting_reg;
  assign ctrl_out = ctrl_reg;
  assign shutdown_out = shdn_reg;

  // --------------------------------------------------
  // Assertions
  // --------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic commit;
  assign commit = (state_reg == WPP_ST_FRAME) && sync_rise && got_word_reg && bit_cnt_reg == `WPP_BIT_ZERO;

  a_shift_capture: assert property ((state_reg == WPP_ST_FRAME) && !sync_rise && sclk_fall
    |=> shift_reg[0] == $past(din_f) && shift_reg[15:1] == $past(shift_reg[14:0]))
    else $error("shift register did not capture serial input");
  a_frame_open: assert property ((state_reg == WPP_ST_IDLE) && sync_fall
    |=> state_reg == WPP_ST_FRAME && bit_cnt_reg == 4'h0)
    else $error("frame did not open on select fall");
  a_commit_write: assert property (commit && cmd == `WPP_CMD_WR_WIPER
    |=> wiper_setting_reg == $past(data))
    else $error("wiper not written on commit");
  a_abort_keeps: assert property ((state_reg == WPP_ST_FRAME) && sync_rise && !commit
    |=> $stable(wiper_setting_reg) && $stable(ctrl_reg) && state_reg == WPP_ST_IDLE)
    else $error("aborted frame changed a register");
  // Pull-low follows the outgoing bit in a frame and is released outside one
  a_sdo_follows: assert property (serial_out_od_oe_out == ((state_reg == WPP_ST_FRAME) && !shift_reg[15])
    && !serial_out_od_out)
    else $error("serial output does not follow shift register");
  a_bit_wrap: assert property ((state_reg == WPP_ST_FRAME) && !sync_rise && sclk_fall && bit_cnt_reg == 4'hF
    |=> bit_cnt_reg == 4'h0 && got_word_reg)
    else $error("bit count did not wrap at sixteen");
  a_store_lock: assert property (store_reg
    |-> $stable(shift_reg) && state_reg == WPP_ST_BUSY)
    else $error("shift register changed during store");
  a_read_next: assert property (commit && cmd == `WPP_CMD_RD_WIPER
    |=> rd_pend_reg && rd_word_reg[9:0] == $past(wiper_setting_reg))
    else $error("read word not staged for next frame");
  // Ready is pulled low exactly while the controller is busy
  a_ready_busy: assert property (ready_od_oe_out == (state_reg == WPP_ST_BUSY))
    else $error("ready not held low for operation");
  // An ordinary command hands ready back within two cycles
  a_ready_release: assert property ((state_reg == WPP_ST_BUSY) && !store_reg
    |-> ##[1:2] !ready_od_oe_out)
    else $error("ready not released after operation");
endmodule
`default_nettype wire

// ==== src/wpp_regs.svh ====
// Constants of the wiper pot serial frame port
`ifndef WPP_REGS_SVH
`define WPP_REGS_SVH
// --------------------------------------------------
// Frame layout
// --------------------------------------------------
`define WPP_WORD_BITS 16
`define WPP_BIT_LAST 4'hF
`define WPP_BIT_ZERO 4'h0
`define WPP_MSB 15
`define WPP_CMD_HI 13
`define WPP_CMD_LO 10
`define WPP_DATA_HI 9
`define WPP_DATA_LO 0
// --------------------------------------------------
// Command codes
// --------------------------------------------------
`define WPP_CMD_NOP 4'h0
`define WPP_CMD_WR_WIPER 4'h1
`define WPP_CMD_RD_WIPER 4'h2
`define WPP_CMD_STORE 4'h3
`define WPP_CMD_REFRESH 4'h4
`define WPP_CMD_RD_OTP 4'h5
`define WPP_CMD_WR_CTRL 4'h6
`define WPP_CMD_RD_CTRL 4'h7
`define WPP_CMD_SHDN 4'h8
// --------------------------------------------------
// Reset values and control fields
// --------------------------------------------------
`define WPP_WIPER_RST 10'h200
`define WPP_CTRL_RST 4'h0
`define WPP_CTRL_PROG_EN 0
`define WPP_WORD_ZERO 16'h0000
// --------------------------------------------------
// Timing
// --------------------------------------------------
`define WPP_SYS_CLK_KHZ 125000
`define WPP_STORE_MS 6
`define WPP_OP_CYCLES 20'h0_0001
`endif

// ==== src/wpp_sync3.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module wpp_sync3 (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic d_in,
  output logic q_out
);
  logic s1_reg, s2_reg, s3_reg, q_reg; // Chain and accepted level
  logic q_next;
  // --------------------------------------------------
  // Accept a change only once stages two and three agree
  // --------------------------------------------------
  always_comb begin
    q_next = q_reg;
    if (s2_reg == s3_reg) begin
      q_next = s3_reg;
    end
  end
  // Stage one is read only by stage two; idle level is high
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
      q_reg <= 1'b1;
    end else begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg <= q_next;
    end
  end
  assign q_out = q_reg;
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking testbench of the wiper pot serial frame port
`include "wpp_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wpp_pkg::*;
  // --------------------------------------------------
  // Clock, reset and pins
  // --------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  wire logic sclk, sync_n, din, sdo_o, sdo_oe, rdy_o, rdy_oe, shdn;
  wire logic [9:0] wiper;
  wire logic [3:0] ctrl;
  wire logic sdo_w = sdo_oe ? sdo_o : 1'b1; // Pull-up on open drain
  wire logic rdy_w = rdy_oe ? rdy_o : 1'b1;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int run = 0; // Current length of a ready-low stretch
  int last_run = 0;
  always #4 sys_clk = ~sys_clk;
  wpp_port #(.STORE_CYCLES(20'h0_0014)) wpp_port_i (.sys_clk_in(sys_clk), .rst_in(rst),
    .sclk_in(sclk), .sync_n_in(sync_n), .din_in(din), .serial_out_od_in(sdo_w),
    .serial_out_od_out(sdo_o), .serial_out_od_oe_out(sdo_oe), .ready_od_in(rdy_w),
    .ready_od_out(rdy_o), .ready_od_oe_out(rdy_oe), .wiper_setting_out(wiper),
    .ctrl_out(ctrl), .shutdown_out(shdn));
  wpp_host_model wpp_host_model_i (.sys_clk_in(sys_clk), .sdo_in(sdo_w), .sclk_out(sclk),
    .sync_n_out(sync_n), .din_out(din));
  // Measure busy stretches and cut a hang short
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (rdy_oe === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_run <= run;
      run <= 0;
    end
    if (cycles == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  // --------------------------------------------------
  // Shared tasks
  // --------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (rdy_w !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    check("ready", 16'(rdy_w), 16'h0001);
  endtask
  task automatic send(input logic [3:0] cmd, input logic [9:0] d);
    wpp_host_model_i.frame({18'h0_0000, cmd, d}, 16);
    wait_ready();
  endtask
  task automatic end_sim();
    if (miscompares == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // --------------------------------------------------
  // Scenarios
  // --------------------------------------------------
  task automatic t_write_read();
    send(`WPP_CMD_WR_WIPER, 10'h155);
    check("wiper", 16'(wiper), 16'h0155);
    check("busy", 16'(last_run), 16'h0001);
    send(`WPP_CMD_RD_WIPER, 10'h000);
    send(`WPP_CMD_NOP, 10'h000);
    check("readback", wpp_host_model_i.rd_word, 16'h0155);
  endtask
  task automatic t_abort();
    wpp_host_model_i.frame({18'h0_0000, `WPP_CMD_WR_WIPER, 10'h3FF}, 8);
    check("short", 16'(wiper), 16'h0155);
    wpp_host_model_i.frame({18'h0_0000, `WPP_CMD_WR_WIPER, 10'h3FF}, 31);
    check("odd", 16'(wiper), 16'h0155);
    check("idle out", 16'(sdo_w), 16'h0001);
  endtask
  task automatic t_daisy();
    logic [15:0] w1;
    w1 = {2'b00, `WPP_CMD_WR_WIPER, 10'h0AA};
    wpp_host_model_i.frame({w1, 2'b00, `WPP_CMD_WR_WIPER, 10'h123}, 32);
    wait_ready();
    check("chain", 16'(wiper), 16'h0123);
    check("forward", wpp_host_model_i.rd_word, w1);
  endtask
  task automatic t_store();
    send(`WPP_CMD_STORE, 10'h000);
    send(`WPP_CMD_REFRESH, 10'h000);
    check("no store", 16'(wiper), 16'h0200);
    send(`WPP_CMD_WR_CTRL, 10'h001);
    check("ctrl", 16'(ctrl), 16'h0001);
    send(`WPP_CMD_WR_WIPER, 10'h155);
    wpp_host_model_i.frame({18'h0_0000, `WPP_CMD_STORE, 10'h000}, 16);
    wpp_host_model_i.frame({18'h0_0000, `WPP_CMD_WR_WIPER, 10'h3FF}, 16);
    wait_ready();
    check("locked", 16'(wiper), 16'h0155);
    check("store busy", 16'(last_run), 16'h0014);
    send(`WPP_CMD_WR_WIPER, 10'h0AA);
    send(`WPP_CMD_REFRESH, 10'h000);
    check("refresh", 16'(wiper), 16'h0155);
    send(`WPP_CMD_RD_OTP, 10'h000);
    send(`WPP_CMD_RD_CTRL, 10'h000);
    check("otp read", wpp_host_model_i.rd_word, 16'h0155);
    send(`WPP_CMD_NOP, 10'h000);
    check("ctrl read", wpp_host_model_i.rd_word, 16'h0001);
  endtask
  task automatic t_shutdown();
    send(`WPP_CMD_SHDN, 10'h001);
    check("shdn on", 16'(shdn), 16'h0001);
    send(`WPP_CMD_SHDN, 10'h000);
    check("shdn off", 16'(shdn), 16'h0000);
  endtask
  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial begin
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    check("rst wiper", 16'(wiper), 16'h0200);
    check("rst ready", 16'(rdy_w), 16'h0001);
    t_write_read();
    t_abort();
    t_daisy();
    t_store();
    t_shutdown();
    end_sim();
  end
endmodule
`default_nettype wire

// ==== verif/wpp_host_model.sv ====
// Host serial controller model that drives frames into the port
`timescale 1ns/1ps
`default_nettype none
module wpp_host_model (
  input wire logic sys_clk_in,
  input wire logic sdo_in,
  output var logic sclk_out,
  output var logic sync_n_out,
  output var logic din_out
);
  // --------------------------------------------------
  // Pin state and readback capture
  // --------------------------------------------------
  logic [15:0] rd_word; // Last 16 bits seen on the serial output
  initial begin
    sclk_out = 1'b0; // Clock stands still low between frames
    sync_n_out = 1'b1;
    din_out = 1'b0;
    rd_word = 16'h0000;
  end
  // Pins only move on system clock falls, away from the sampling edge
  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  // --------------------------------------------------
  // One frame of nbits, sent MSB first
  // --------------------------------------------------
  task automatic frame(input logic [31:0] w, input int nbits);
    sync_n_out = 1'b0;
    hold(8);
    for (int i = nbits - 1; i >= 0; i--) begin
      din_out = w[i];
      hold(2); // Data settles before the clock rises, never on its fall
      sclk_out = 1'b1;
      hold(4); // 64 ns period keeps far below the clock ceiling
      rd_word = {rd_word[14:0], sdo_in}; // Sampled before the fall moves it
      sclk_out = 1'b0;
      hold(2);
    end
    hold(2);
    sync_n_out = 1'b1; // Bit count decides commit or drop
    din_out = ~din_out; // Released line must not look like stale data
    hold(12);
  endtask
endmodule
`default_nettype wire
